// ### hdl/sspc_pkg.sv
// package: register map, field layout and types for suspend/status pin control
package sspc_pkg;
   localparam logic [11:0] SSPC_LEVEL_IDX = 12'h06a;
   localparam logic [11:0] SSPC_DRIVE_IDX = 12'h06b;
   localparam logic [11:0] SSPC_REV_IDX = 12'h260;
   localparam logic [11:0] SSPC_STAT_IDX = 12'h262;
   localparam int SSPC_NPINS = 14;
   localparam logic [15:0] SSPC_PIN_MASK = 16'h3ccf;
   localparam int SSPC_OVR_BIT = 15;
   localparam int SSPC_ST2_LVL_BIT = 13;
   localparam int SSPC_SEL2_LO = 10;
   localparam int SSPC_DRV2_LO = 8;
   localparam int SSPC_ST1_LVL_BIT = 5;
   localparam int SSPC_SECOND_STATUS_SELECT_LO = 2;
   localparam int SSPC_DRV1_BIT = 1;
   localparam logic [1:0] SSPC_DRV_OD = 2'h1;
   localparam logic [1:0] SSPC_DRV_PP = 2'h2;
   localparam logic [15:0] SSPC_STAT_RST = 16'h0200;
   localparam logic [15:0] SSPC_DRIVE_WMASK = 16'hbccf;
   localparam logic [15:0] SSPC_STAT_WMASK = 16'h1f1e;
   localparam logic [7:0] SSPC_POWER_100MA = 8'h32;
   localparam logic [15:0] SSPC_REVISION = 16'h0001; // arbitrary value
   typedef enum logic [2:0] {
      SSPC_SEL_SUSP_RST_A = 3'h0,
      SSPC_SEL_SUSP_HI = 3'h1,
      SSPC_SEL_PWR_HI = 3'h2,
      SSPC_SEL_RST_HI = 3'h3,
      SSPC_SEL_SUSP_RST_B = 3'h4,
      SSPC_SEL_SUSP_LO = 3'h5,
      SSPC_SEL_PWR_LO = 3'h6,
      SSPC_SEL_RST_LO = 3'h7
   } sspc_sel_t;
   typedef struct packed {
      logic suspended;
      logic bus_reset;
      logic configured;
      logic [7:0] max_power;
   } sspc_usb_state_t;
   typedef struct packed {
      logic [SSPC_NPINS-1:0] out;
      logic [SSPC_NPINS-1:0] oe_n;
   } sspc_pins_t;
endpackage

// ### hdl/sspc_stat_pin.sv
// status pin encoder: select code and drive style to pin signals
`timescale 1ns/1ps
`default_nettype none
module sspc_stat_pin (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic first_pin,
   input wire logic [2:0] sel,
   input wire logic [1:0] drive,
   input wire sspc_pkg::sspc_usb_state_t usb,
   output logic pin_out,
   output logic pin_oe_n
);
   import sspc_pkg::*;
   logic high_power;
   logic cond;
   logic active_low;
   logic level;
   always_comb begin
      high_power = usb.max_power > SSPC_POWER_100MA;
      active_low = sel[2];
      case (sel)
         SSPC_SEL_SUSP_RST_A, SSPC_SEL_SUSP_RST_B: begin
            cond = usb.suspended | usb.bus_reset;
            active_low = first_pin;
         end
         SSPC_SEL_SUSP_HI, SSPC_SEL_SUSP_LO: cond = usb.suspended;
         SSPC_SEL_PWR_HI, SSPC_SEL_PWR_LO: cond = usb.suspended | (high_power & ~usb.configured);
         SSPC_SEL_RST_HI, SSPC_SEL_RST_LO: cond = usb.bus_reset;
         default: cond = 1'b0;
      endcase
      level = cond ^ active_low;
   end
   // open drain only releases when high; invalid drive codes treated as driven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b0;
      end else begin
         pin_out <= level;
         pin_oe_n <= (drive == SSPC_DRV_OD) & level;
      end
   end
endmodule
`default_nettype wire

// ### hdl/sspc_top.sv
// suspend/status pin control top with apb register slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sspc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sspc_pkg::sspc_usb_state_t usb,
   input wire sspc_pkg::sspc_pins_t normal,
   input wire logic [sspc_pkg::SSPC_NPINS-1:0] pin_in,
   output sspc_pkg::sspc_pins_t pins,
   output logic stat1_out,
   output logic stat1_oe_n,
   input wire logic stat1_in,
   output logic stat2_out,
   output logic stat2_oe_n,
   input wire logic stat2_in
);
   import sspc_pkg::*;
   logic [15:0] level_reg;
   logic [15:0] drive_reg;
   logic [15:0] stat_reg;
   logic [SSPC_NPINS-1:0] held_out_reg;
   logic [SSPC_NPINS-1:0] held_oe_reg;
   logic susp_d_reg;
   logic setup;
   logic wr;
   logic hit;
   logic [15:0] rdata_next;
   sspc_pins_t pins_next;
   logic [11:0] idx;

   typedef enum logic [1:0] {
      SSPC_IDLE = 2'b01,
      SSPC_ACC = 2'b10
   } sspc_st_t;
   sspc_st_t st_reg;

   function automatic logic [11:0] word_idx(input logic [31:0] a);
      return a[13:2];
   endfunction

   function automatic logic [SSPC_NPINS-1:0] pin_bits(input logic [15:0] r);
      return r[SSPC_NPINS-1:0] & SSPC_PIN_MASK[SSPC_NPINS-1:0];
   endfunction

   assign idx = word_idx(paddr);
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & (st_reg == SSPC_ACC);

   always_comb begin
      hit = 1'b1;
      case (idx)
         SSPC_LEVEL_IDX: rdata_next = level_reg;
         SSPC_DRIVE_IDX: rdata_next = drive_reg;
         SSPC_REV_IDX: rdata_next = SSPC_REVISION;
         SSPC_STAT_IDX: begin
            rdata_next = stat_reg;
            rdata_next[SSPC_ST2_LVL_BIT] = stat2_in;
            rdata_next[SSPC_ST1_LVL_BIT] = stat1_in;
         end
         default: begin
            rdata_next = 16'h0000;
            hit = 1'b0;
         end
      endcase
   end

   // no wait state: setup then access answered on the first access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= SSPC_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         case (st_reg)
            SSPC_IDLE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               if (setup) begin
                  st_reg <= SSPC_ACC;
                  pready <= 1'b1;
                  pslverr <= ~hit;
                  prdata <= {16'h0000, pwrite ? 16'h0000 : rdata_next};
               end
            end
            SSPC_ACC: begin
               st_reg <= SSPC_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default: st_reg <= SSPC_IDLE;
         endcase
      end
   end

   // reserved bits forced to zero; software is expected to write zeros anyway
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 16'h0000;
         drive_reg <= 16'h0000;
         stat_reg <= SSPC_STAT_RST;
      end else if (wr && hit) begin
         if (idx == SSPC_LEVEL_IDX) begin
            level_reg <= pwdata[15:0] & SSPC_PIN_MASK;
         end
         if (idx == SSPC_DRIVE_IDX) begin
            drive_reg <= pwdata[15:0] & SSPC_DRIVE_WMASK;
         end
         if (idx == SSPC_STAT_IDX) begin
            stat_reg <= pwdata[15:0] & SSPC_STAT_WMASK;
         end
      end
   end

   // capture pin state at suspend entry so override-off keeps it stable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         susp_d_reg <= 1'b0;
         held_out_reg <= '0;
         held_oe_reg <= '1;
      end else begin
         susp_d_reg <= usb.suspended;
         if (usb.suspended && !susp_d_reg) begin
            held_out_reg <= pins_next.out;
            held_oe_reg <= pins_next.oe_n;
         end
      end
   end

   always_comb begin
      if (usb.suspended && drive_reg[SSPC_OVR_BIT]) begin
         pins_next.out = pin_bits(level_reg);
         pins_next.oe_n = pin_bits(drive_reg) & pin_bits(level_reg);
      end else if (usb.suspended && susp_d_reg) begin
         pins_next.out = held_out_reg;
         pins_next.oe_n = held_oe_reg;
      end else begin
         pins_next = normal;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins.out <= '0;
         pins.oe_n <= '1;
      end else begin
         pins <= pins_next;
      end
   end

   sspc_stat_pin u_stat1 (
      .pclk(pclk),
      .presetn(presetn),
      .first_pin(1'b1),
      .sel(stat_reg[SSPC_SECOND_STATUS_SELECT_LO +: 3]),
      .drive({~stat_reg[SSPC_DRV1_BIT], stat_reg[SSPC_DRV1_BIT]}),
      .usb(usb),
      .pin_out(stat1_out),
      .pin_oe_n(stat1_oe_n)
   );

   sspc_stat_pin u_stat2 (
      .pclk(pclk),
      .presetn(presetn),
      .first_pin(1'b0),
      .sel(stat_reg[SSPC_SEL2_LO +: 3]),
      .drive(stat_reg[SSPC_DRV2_LO +: 2]),
      .usb(usb),
      .pin_out(stat2_out),
      .pin_oe_n(stat2_oe_n)
   );

   property p_override_level;
      @(posedge pclk) disable iff (!presetn)
      (usb.suspended && drive_reg[SSPC_OVR_BIT]) |=> (pins.out == pin_bits($past(level_reg)));
   endproperty
   a_override_level: assert property (p_override_level) else $error("override level wrong");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (usb.suspended && susp_d_reg && !drive_reg[SSPC_OVR_BIT]) |=> (pins.out == held_out_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("suspend hold lost");

   property p_od;
      @(posedge pclk) disable iff (!presetn)
      (usb.suspended && drive_reg[SSPC_OVR_BIT])
         |=> (pins.oe_n == (pin_bits($past(drive_reg)) & pin_bits($past(level_reg))));
   endproperty
   a_od: assert property (p_od) else $error("drive style wrong");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      !usb.suspended |=> (pins == $past(normal));
   endproperty
   a_wake: assert property (p_wake) else $error("normal pins not restored");

   property p_rev;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == SSPC_REV_IDX) |=> (prdata[15:0] == SSPC_REVISION);
   endproperty
   a_rev: assert property (p_rev) else $error("revision read wrong");

   property p_stat_live;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == SSPC_STAT_IDX)
         |=> (prdata[SSPC_ST1_LVL_BIT] == $past(stat1_in) && prdata[SSPC_ST2_LVL_BIT] == $past(stat2_in));
   endproperty
   a_stat_live: assert property (p_stat_live) else $error("status level readback wrong");

   property p_stat2_rst;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_RST_LO && usb.bus_reset) |=> !stat2_out;
   endproperty
   a_stat2_rst: assert property (p_stat2_rst) else $error("second pin not low in reset");

   property p_stat1_low;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SECOND_STATUS_SELECT_LO +: 3] == SSPC_SEL_SUSP_RST_A && usb.suspended) |=> !stat1_out;
   endproperty
   a_stat1_low: assert property (p_stat1_low) else $error("first pin not low");

   property p_stat2_hi;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_SUSP_RST_A && usb.suspended) |=> stat2_out;
   endproperty
   a_stat2_hi: assert property (p_stat2_hi) else $error("second pin not high");

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("apb answer timing wrong");

   property p_stat2_susp_lo;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_SUSP_LO && usb.suspended) |=> !stat2_out;
   endproperty
   a_stat2_susp_lo: assert property (p_stat2_susp_lo) else $error("second pin not low in suspend");

   property p_stat2_rst_hi;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_RST_HI && usb.bus_reset) |=> stat2_out;
   endproperty
   a_stat2_rst_hi: assert property (p_stat2_rst_hi) else $error("second pin not high in reset");

   property p_stat2_pwr_hi;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_PWR_HI && !usb.configured && usb.max_power > SSPC_POWER_100MA)
         |=> stat2_out;
   endproperty
   a_stat2_pwr_hi: assert property (p_stat2_pwr_hi) else $error("high power unconfigured not flagged");

   property p_stat2_pwr_low;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SEL2_LO +: 3] == SSPC_SEL_PWR_HI && !usb.suspended && usb.max_power <= SSPC_POWER_100MA)
         |=> !stat2_out;
   endproperty
   a_stat2_pwr_low: assert property (p_stat2_pwr_low) else $error("low power flagged outside suspend");

   property p_stat1_hi;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SECOND_STATUS_SELECT_LO +: 3] == SSPC_SEL_SUSP_HI && usb.suspended) |=> stat1_out;
   endproperty
   a_stat1_hi: assert property (p_stat1_hi) else $error("first pin not high in suspend");

   property p_stat1_rst_b;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_SECOND_STATUS_SELECT_LO +: 3] == SSPC_SEL_SUSP_RST_B && usb.bus_reset) |=> !stat1_out;
   endproperty
   a_stat1_rst_b: assert property (p_stat1_rst_b) else $error("first pin not low in reset");

   property p_stat2_od;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_DRV2_LO +: 2] == SSPC_DRV_OD) |=> (stat2_oe_n == stat2_out);
   endproperty
   a_stat2_od: assert property (p_stat2_od) else $error("second pin open drain wrong");

   property p_stat2_pp;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[SSPC_DRV2_LO +: 2] == SSPC_DRV_PP) |=> !stat2_oe_n;
   endproperty
   a_stat2_pp: assert property (p_stat2_pp) else $error("second pin not driven");

   property p_stat1_od;
      @(posedge pclk) disable iff (!presetn)
      stat_reg[SSPC_DRV1_BIT] |=> (stat1_oe_n == stat1_out);
   endproperty
   a_stat1_od: assert property (p_stat1_od) else $error("first pin open drain wrong");

   property p_stat1_pp;
      @(posedge pclk) disable iff (!presetn)
      !stat_reg[SSPC_DRV1_BIT] |=> !stat1_oe_n;
   endproperty
   a_stat1_pp: assert property (p_stat1_pp) else $error("first pin not driven");

   property p_level_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == SSPC_LEVEL_IDX) |=> (level_reg == ($past(pwdata[15:0]) & SSPC_PIN_MASK));
   endproperty
   a_level_wr: assert property (p_level_wr) else $error("level write lost");

   property p_stat_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == SSPC_STAT_IDX) |=> (stat_reg == ($past(pwdata[15:0]) & SSPC_STAT_WMASK));
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status write lost");

   property p_drive_rsv;
      @(posedge pclk) disable iff (!presetn)
      (drive_reg & ~SSPC_DRIVE_WMASK) == 16'h0000;
   endproperty
   a_drive_rsv: assert property (p_drive_rsv) else $error("reserved drive bits set");

   property p_entry_normal;
      @(posedge pclk) disable iff (!presetn)
      (usb.suspended && !susp_d_reg && !drive_reg[SSPC_OVR_BIT]) |=> (pins == $past(normal));
   endproperty
   a_entry_normal: assert property (p_entry_normal) else $error("suspend entry disturbed pins");

   property p_hold_oe;
      @(posedge pclk) disable iff (!presetn)
      (usb.suspended && susp_d_reg && !drive_reg[SSPC_OVR_BIT]) |=> (pins.oe_n == held_oe_reg);
   endproperty
   a_hold_oe: assert property (p_hold_oe) else $error("suspend drive hold lost");

   c_override: cover property (@(posedge pclk) disable iff (!presetn)
      usb.suspended && drive_reg[SSPC_OVR_BIT]);
   c_hold: cover property (@(posedge pclk) disable iff (!presetn)
      usb.suspended && susp_d_reg && !drive_reg[SSPC_OVR_BIT]);
   c_wr_level: cover property (@(posedge pclk) disable iff (!presetn)
      wr && idx == SSPC_LEVEL_IDX);
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   c_pwr_unconf: cover property (@(posedge pclk) disable iff (!presetn)
      usb.max_power > SSPC_POWER_100MA && !usb.configured);
endmodule
`default_nettype wire

// ### test/sspc_periph.sv
// peripherals on the modem and status pins, with pull-ups on every line
`timescale 1ns/1ps
`default_nettype none
module sspc_periph (
   input wire sspc_pkg::sspc_pins_t pins,
   input wire logic stat1_out,
   input wire logic stat1_oe_n,
   input wire logic stat2_out,
   input wire logic stat2_oe_n,
   output logic [sspc_pkg::SSPC_NPINS-1:0] pin_in,
   output logic stat1_in,
   output logic stat2_in
);
   import sspc_pkg::*;
   // a released line rises to the pull-up, never keeps its last value
   assign pin_in = pins.out | pins.oe_n;
   assign stat1_in = stat1_oe_n | stat1_out;
   assign stat2_in = stat2_oe_n | stat2_out;
endmodule
`default_nettype wire

// ### test/suspend_status_pin_control_tb.sv
// self-checking bench for the suspend and status pin control block
`timescale 1ns/1ps
`default_nettype none
module suspend_status_pin_control_tb;
   import sspc_pkg::*;
   localparam logic [13:0] MASK = 14'h3ccf;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   sspc_usb_state_t usb = '{1'b0, 1'b0, 1'b1, 8'h32};
   sspc_pins_t normal = '{14'h1555, 14'h0000};
   sspc_pins_t pins;
   logic [SSPC_NPINS-1:0] pin_in;
   logic stat1_out, stat1_oe_n, stat1_in, stat2_out, stat2_oe_n, stat2_in;
   int n_fail = 0;
   int n_checks = 0;
   int cycles = 0;

   always #4 pclk = ~pclk;

   sspc_top sspc_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .usb(usb), .normal(normal), .pin_in(pin_in), .pins(pins),
      .stat1_out(stat1_out), .stat1_oe_n(stat1_oe_n), .stat1_in(stat1_in),
      .stat2_out(stat2_out), .stat2_oe_n(stat2_oe_n), .stat2_in(stat2_in));

   sspc_periph sspc_periph_inst (
      .pins(pins), .stat1_out(stat1_out), .stat1_oe_n(stat1_oe_n), .stat2_out(stat2_out),
      .stat2_oe_n(stat2_oe_n), .pin_in(pin_in), .stat1_in(stat1_in), .stat2_in(stat2_in));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // a hang in the bus handshake lands here instead of running forever
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // request held until pready is sampled high, then released
   task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {18'h0, idx, 2'b00};
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic e;
      bus(1'b0, idx, 16'h0, q, e);
      chk(q, exp, what);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [15:0] d);
      logic [31:0] q;
      logic e;
      bus(1'b1, idx, d, q, e);
   endtask

   task automatic t_reset();
      logic [31:0] q;
      logic e;
      rd(SSPC_LEVEL_IDX, 32'h0, "level reset");
      rd(SSPC_DRIVE_IDX, 32'h0, "drive reset");
      rd(SSPC_STAT_IDX, 32'h0220, "status reset");
      rd(SSPC_REV_IDX, {16'h0, SSPC_REVISION}, "revision");
      wr(SSPC_REV_IDX, 16'hffff);
      rd(SSPC_REV_IDX, {16'h0, SSPC_REVISION}, "revision kept");
      bus(1'b0, 12'h100, 16'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      $display("reset test done");
   endtask

   task automatic t_override();
      wr(SSPC_LEVEL_IDX, 16'h2c45);
      rd(SSPC_LEVEL_IDX, 32'h2c45, "level readback");
      wr(SSPC_DRIVE_IDX, 16'h8c81);
      usb.suspended <= 1'b1;
      tick(3);
      chk(32'(pins.out & MASK), 32'h2c45, "suspend level");
      chk(32'(pins.oe_n & MASK), 32'h0c01, "suspend drive");
      chk(32'(pin_in & MASK), 32'h2c45, "suspend pads");
      usb.suspended <= 1'b0;
      tick(3);
      chk(32'(pins), 32'(normal), "resume");
      $display("override test done");
   endtask

   task automatic t_hold();
      wr(SSPC_DRIVE_IDX, 16'h0c81);
      usb.suspended <= 1'b1;
      tick(2);
      normal.out <= 14'h2aaa;
      tick(3);
      chk(32'(pins.out & MASK), 32'h1445, "hold");
      usb.suspended <= 1'b0;
      tick(3);
      chk(32'(pins.out), 32'h2aaa, "release");
      $display("hold test done");
   endtask

   task automatic t_status();
      logic [2:0] c;
      logic s, r, cf, hp, a, e1, e2;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(SSPC_STAT_IDX, {3'h0, c, 2'h2, 3'h0, c, 2'h0});
         for (int k = 0; k < 5; k++) begin
            s = (k == 1);
            r = (k == 2);
            cf = (k < 3);
            hp = (k == 4);
            usb <= '{s, r, cf, hp ? 8'h33 : 8'h32};
            tick(3);
            a = (c[1:0] == 2'h3) ? r : (c[1:0] == 2'h1) ? s : (c[1:0] == 2'h2) ? (s | (hp & ~cf)) : (s | r);
            e2 = (c[2] && c[1:0] != 2'h0) ? ~a : a;
            e1 = (c[2] || c[1:0] == 2'h0) ? ~a : a;
            chk({28'h0, stat2_out, stat2_oe_n, stat1_out, stat1_oe_n}, {28'h0, e2, 1'b0, e1, 1'b0},
                "status pins");
         end
      end
      $display("status select test done");
   endtask

   task automatic t_readback();
      wr(SSPC_STAT_IDX, 16'h0506);
      usb <= '{1'b1, 1'b0, 1'b1, 8'h32};
      tick(3);
      rd(SSPC_STAT_IDX, 32'h2526, "pads high");
      chk({30'h0, stat2_oe_n, stat1_oe_n}, 32'h3, "open drain released");
      usb.suspended <= 1'b0;
      tick(3);
      rd(SSPC_STAT_IDX, 32'h0506, "pads low");
      $display("readback test done");
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_override();
      t_hold();
      t_status();
      t_readback();
      test_done();
   end
endmodule
`default_nettype wire
